// File: ccd_clock_sequencer.sv
`timescale 1ns/1ps
module ccd_clock_sequencer
  import ccd_seq_pkg::*;
#(
  parameter int ROWS = 1152,
  parameter int COLS = 1252
)
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       frame_start,
  input  wire logic       cfg_fast_dir,
  input  wire logic       cfg_frame_transfer,
  input  wire logic       cfg_short_ph2,
  output logic [2:0]      image_a_ph,
  output logic [2:0]      image_b_ph,
  output logic            reg_ph1,
  output logic            reg_ph2,
  output logic            out_reset,
  output logic            busy,
  output logic            frame_done
);
  import ccd_seq_pkg::*;

  localparam int CNT_W = 11;

  seq_timer_if tmr ();

  seq_timer u_timer (
    .clk   (clk),
    .rst_n (rst_n),
    .tmr   (tmr)
  );

  seq_state_t       state_reg;
  seq_state_t       state_next;
  logic [2:0]       istep_reg;
  logic [2:0]       istep_next;
  logic [2:0]       pstep_reg;
  logic [2:0]       pstep_next;
  logic [CNT_W-1:0] row_reg;
  logic [CNT_W-1:0] row_next;
  logic [CNT_W-1:0] col_reg;
  logic [CNT_W-1:0] col_next;
  logic             fast_reg;
  logic             fast_next;
  logic             ft_reg;
  logic             ft_next;
  logic             short_reg;
  logic             short_next;
  logic [2:0]       kind_next;

  // image phase pattern {ph3,ph2,ph1}: 3, 3+1, 1, 1+2, 2, 2+3, 3
  function automatic logic [2:0] img_pattern(input logic [2:0] s);
    case (s)
      3'h0:    img_pattern = 3'h4;
      3'h1:    img_pattern = 3'h5;
      3'h2:    img_pattern = 3'h1;
      3'h3:    img_pattern = 3'h3;
      3'h4:    img_pattern = 3'h2;
      3'h5:    img_pattern = 3'h6;
      3'h6:    img_pattern = 3'h4;
      default: img_pattern = 3'h0;
    endcase
  endfunction : img_pattern

  // odd steps are overlaps, even steps have one phase high
  function automatic logic [TMR_W-1:0] img_dwell(input logic [2:0] s);
    if (s[0])
      img_dwell = TMR_W'(IMG_OVL_CYC);
    else if (IMG_SGL_CYC > IMG_LOW_CYC)
      img_dwell = TMR_W'(IMG_SGL_CYC);
    else
      img_dwell = TMR_W'(IMG_LOW_CYC);
  endfunction : img_dwell

  // fast direction runs the same steps rotated so phase one leads
  function automatic logic [2:0] pix_kind(input logic [2:0] s,
                                          input logic       fast);
    if (!fast)
      pix_kind = s;
    else if (s >= 3'h2)
      pix_kind = s - 3'h2;
    else
      pix_kind = s + 3'h3;
  endfunction : pix_kind

  function automatic logic [TMR_W-1:0] pix_dwell(input logic [2:0] k,
                                                 input logic       short);
    case (k)
      K_PH2_RST: pix_dwell = TMR_W'(RST_CYC);
      K_PH2:     pix_dwell = short ? TMR_W'(PH2_SHORT_CYC)
                                   : TMR_W'(PH2_REST_CYC);
      K_PH1:     pix_dwell = short ? TMR_W'(PH1_LONG_CYC)
                                   : TMR_W'(PH1_CYC);
      default:   pix_dwell = TMR_W'(REG_OVL_CYC);
    endcase
  endfunction : pix_dwell

  // sequence control: frame, row, pixel and step walking
  always_comb
  begin
    state_next = state_reg;
    istep_next = istep_reg;
    pstep_next = pstep_reg;
    row_next   = row_reg;
    col_next   = col_reg;
    fast_next  = fast_reg;
    ft_next    = ft_reg;
    short_next = short_reg;
    tmr.load   = 1'b0;
    tmr.len    = '0;
    case (state_reg)
      ST_IDLE:
      begin
        if (frame_start)
        begin
          // modes sampled only here, so a frame never changes mid-way
          fast_next  = cfg_fast_dir;
          ft_next    = cfg_frame_transfer;
          short_next = cfg_short_ph2;
          row_next   = '0;
          istep_next = 3'h0;
          state_next = ST_IMG;
          tmr.load   = 1'b1;
          tmr.len    = img_dwell(3'h0);
        end
      end
      ST_IMG:
      begin
        if (tmr.done)
        begin
          if (istep_reg == 3'(IMG_LAST_STEP))
          begin
            state_next = ST_DIR;
            tmr.load   = 1'b1;
            tmr.len    = TMR_W'(DIR_CYC);
          end
          else
          begin
            istep_next = istep_reg + 3'h1;
            tmr.load   = 1'b1;
            tmr.len    = img_dwell(istep_reg + 3'h1);
          end
        end
      end
      ST_DIR:
      begin
        if (tmr.done)
        begin
          state_next = ST_PIX;
          pstep_next = 3'h0;
          col_next   = '0;
          tmr.load   = 1'b1;
          tmr.len    = pix_dwell(pix_kind(3'h0, fast_reg), short_reg);
        end
      end
      ST_PIX:
      begin
        if (tmr.done)
        begin
          if (pstep_reg != 3'(PIX_LAST_STEP))
          begin
            pstep_next = pstep_reg + 3'h1;
            tmr.load   = 1'b1;
            tmr.len    = pix_dwell(pix_kind(pstep_reg + 3'h1, fast_reg),
                                   short_reg);
          end
          else if (col_reg != CNT_W'(COLS - 1))
          begin
            col_next   = col_reg + CNT_W'(1);
            pstep_next = 3'h0;
            tmr.load   = 1'b1;
            tmr.len    = pix_dwell(pix_kind(3'h0, fast_reg), short_reg);
          end
          else
          begin
            state_next = ST_DRI;
            tmr.load   = 1'b1;
            tmr.len    = TMR_W'(DRI_CYC);
          end
        end
      end
      ST_DRI:
      begin
        if (tmr.done)
        begin
          if (row_reg == CNT_W'(ROWS - 1))
            state_next = ST_IDLE;
          else
          begin
            row_next   = row_reg + CNT_W'(1);
            istep_next = 3'h0;
            state_next = ST_IMG;
            tmr.load   = 1'b1;
            tmr.len    = img_dwell(3'h0);
          end
        end
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_IDLE;
      istep_reg <= 3'h0;
      pstep_reg <= 3'h0;
      row_reg   <= '0;
      col_reg   <= '0;
      fast_reg  <= 1'b0; // low-noise amp by default
      ft_reg    <= 1'b0;
      short_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      istep_reg <= istep_next;
      pstep_reg <= pstep_next;
      row_reg   <= row_next;
      col_reg   <= col_next;
      fast_reg  <= fast_next;
      ft_reg    <= ft_next;
      short_reg <= short_next;
    end
  end

  logic [2:0] img_ph_reg;
  logic [2:0] img_ph_next;
  logic [2:0] img_a_reg;
  logic [2:0] img_a_next;
  logic       ph1_reg;
  logic       ph1_next;
  logic       ph2_reg;
  logic       ph2_next;
  logic       rst_pulse_reg;
  logic       rst_pulse_next;
  logic       busy_reg;
  logic       busy_next;
  logic       done_reg;
  logic       done_next;

  assign kind_next = pix_kind(pstep_next, fast_next);

  // pin levels from the next state, so every pin is a flop
  always_comb
  begin
    img_ph_next    = 3'h0; // all low while integrating
    ph1_next       = 1'b1; // register open to take the row
    ph2_next       = 1'b1;
    rst_pulse_next = 1'b0;
    if (state_next == ST_IMG)
      img_ph_next = img_pattern(istep_next);
    if (state_next == ST_PIX)
    begin
      case (kind_next)
        K_PH2_RST:
        begin
          ph1_next       = 1'b0;
          rst_pulse_next = 1'b1;
        end
        K_PH2:   ph1_next = 1'b0;
        K_PH1:   ph2_next = 1'b0;
        default: ph1_next = 1'b1;
      endcase
    end
    // section A idles low in frame transfer to keep collecting
    img_a_next = ft_next ? 3'h0 : img_ph_next;
    busy_next  = (state_next != ST_IDLE);
    done_next  = (state_reg == ST_DRI) && (state_next == ST_IDLE);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      img_ph_reg    <= 3'h0;
      img_a_reg     <= 3'h0;
      ph1_reg       <= 1'b1;
      ph2_reg       <= 1'b1;
      rst_pulse_reg <= 1'b0;
      busy_reg      <= 1'b0;
      done_reg      <= 1'b0;
    end
    else
    begin
      img_ph_reg    <= img_ph_next;
      img_a_reg     <= img_a_next;
      ph1_reg       <= ph1_next;
      ph2_reg       <= ph2_next;
      rst_pulse_reg <= rst_pulse_next;
      busy_reg      <= busy_next;
      done_reg      <= done_next;
    end
  end

  assign image_b_ph = img_ph_reg;
  assign image_a_ph = img_a_reg;
  assign reg_ph1    = ph1_reg;
  assign reg_ph2    = ph2_reg;
  assign out_reset  = rst_pulse_reg;
  assign busy       = busy_reg;
  assign frame_done = done_reg;

endmodule : ccd_clock_sequencer

// File: ccd_clock_sequencer_bench.sv
`timescale 1ns/1ps
module ccd_clock_sequencer_bench;
  import ccd_seq_pkg::*;
  localparam int ROWS = 2;
  localparam int COLS = 3;
  typedef struct packed {
    logic [15:0] rows;
    logic [15:0] pix;
    logic        fast;
    logic        a_act;
    logic [15:0] per;
  } note_t;

  logic       clk = 1'b0;
  logic       rst_n, frame_start, cfg_fast_dir, cfg_frame_transfer;
  logic       cfg_short_ph2, reg_ph1, reg_ph2, out_reset, busy, frame_done;
  logic [2:0] image_a_ph, image_b_ph;
  logic       fast, bad, a_seen, orst;
  int         rows, pix, base_rows, base_pix, cyc, rise_cyc, per;
  int         error_cnt = 0;
  int         n_compared = 0;
  note_t      q[$];

  always #4 clk = ~clk;

  ccd_clock_sequencer #(.ROWS(ROWS), .COLS(COLS)) u_dut (
    .clk(clk), .rst_n(rst_n), .frame_start(frame_start),
    .cfg_fast_dir(cfg_fast_dir), .cfg_frame_transfer(cfg_frame_transfer),
    .cfg_short_ph2(cfg_short_ph2), .image_a_ph(image_a_ph),
    .image_b_ph(image_b_ph), .reg_ph1(reg_ph1), .reg_ph2(reg_ph2),
    .out_reset(out_reset), .busy(busy), .frame_done(frame_done));

  ccd_sensor_model u_sensor (
    .image_b_ph(image_b_ph), .reg_ph1(reg_ph1), .reg_ph2(reg_ph2),
    .out_reset(out_reset), .rows(rows), .pix(pix), .fast(fast), .bad(bad));

  task automatic check(input logic [63:0] g, input logic [63:0] e,
                       input string what);
    n_compared++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch at %0t: %s got %0h exp %0h", $time, what, g, e);
    end
  endtask : check

  task automatic summarize();
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  // start a frame and, with push, note its outcome; poke retries with other settings
  task automatic start_frame(input logic fd, ft, sh, push, poke);
    note_t n;
    @(posedge clk);
    #1;
    {frame_start, cfg_fast_dir, cfg_frame_transfer, cfg_short_ph2} =
      {1'b1, fd, ft, sh};
    base_rows = rows;
    base_pix = pix;
    a_seen = 1'b0;
    n = {16'(ROWS), 16'(ROWS * COLS), fd, ~ft,
         16'(sh ? PIX_CYC : 2 * HALF_CYC + 2 * REG_OVL_CYC)};
    if (push)
      q.push_back(n);
    @(posedge clk);
    #1;
    frame_start = 1'b0;
    @(posedge clk);
    #1;
    check({busy, image_b_ph}, 4'hC, "frame opening");
    if (poke)
    begin
      repeat (100 + $urandom % 400) @(posedge clk);
      #1;
      // a busy sequencer must ignore this, random short mode included
      {frame_start, cfg_fast_dir, cfg_frame_transfer, cfg_short_ph2} =
        {1'b1, ~fd, ~ft, 1'($urandom)};
      @(posedge clk);
      #1;
      frame_start = 1'b0;
    end
  endtask : start_frame

  // bounded wait; a hang leaves busy high and is caught
  task automatic wait_done();
    int i;
    for (i = 0; i < 20000 && frame_done !== 1'b1; i++)
    begin
      @(posedge clk);
      #1;
    end
    check(busy, 1'b0, "busy after frame end");
  endtask : wait_done

  // measure each frame and settle it against the oldest note
  always @(posedge clk)
  begin
    note_t n;
    cyc++;
    if (image_a_ph !== 3'h0)
      a_seen = 1'b1;
    if (out_reset === 1'b1 && orst !== 1'b1)
    begin
      per = cyc - rise_cyc;
      rise_cyc = cyc;
    end
    orst = out_reset;
    if (frame_done === 1'b1)
    begin
      if (q.size() == 0)
        check(0, 1, "frame end with no start");
      else
      begin
        n = q.pop_front();
        check(rows - base_rows, n.rows, "rows");
        check(pix - base_pix, n.pix, "pixels");
        check(fast, n.fast, "direction");
        check(a_seen, n.a_act, "section A");
        check(per, n.per, "pixel period");
      end
    end
  end

  // main sequence
  initial
  begin
    int k;
    int seed;
    {rst_n, frame_start, cfg_fast_dir, cfg_frame_transfer} = 4'h0;
    {cfg_short_ph2, a_seen, orst} = 3'h0;
    {cyc, rise_cyc, per, base_rows, base_pix} = '0;
    seed = $urandom(32'hB04C);
    repeat (16) @(posedge clk);
    #1;
    check({image_a_ph, image_b_ph, reg_ph1, reg_ph2, out_reset, busy,
           frame_done}, 11'h018, "reset state");
    rst_n = 1'b1;
    for (k = 0; k < 4; k++)
    begin
      start_frame(k[0], k[1], k[0] ^ k[1], 1'b1, k == 1);
      wait_done();
    end
    // cut a frame short by reset, then restart at once
    start_frame(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    repeat (1000 + $urandom % 400) @(posedge clk);
    #1;
    rst_n = 1'b0;
    @(posedge clk);
    #1;
    check({image_a_ph, image_b_ph, reg_ph1, reg_ph2, out_reset, busy,
           frame_done}, 11'h018, "mid-run reset");
    rst_n = 1'b1;
    start_frame(1'b0, 1'b1, 1'b1, 1'b1, 1'b0);
    wait_done();
    // let the monitor settle the last frame before the verdict
    @(posedge clk);
    #1;
    check(q.size(), 0, "frames left unchecked");
    check(bad, 1'b0, "sensor sequence");
    summarize();
  end

  // watchdog well past the expected run of some 43000 cycles
  initial
  begin
    #(8 * 60000);
    error_cnt++;
    $display("mismatch at %0t: run did not finish", $time);
    summarize();
  end
endmodule : ccd_clock_sequencer_bench

// File: ccd_sensor_model.sv
`timescale 1ns/1ps
// sensor side: rows landing in the register, pixels seen, direction
module ccd_sensor_model
(
  input  wire logic [2:0] image_b_ph,
  input  wire logic       reg_ph1,
  input  wire logic       reg_ph2,
  input  wire logic       out_reset,
  output int              rows,
  output int              pix,
  output logic            fast,
  output logic            bad
);
  logic [2:0] prev;
  logic       armed;
  int         steps;

  // counters start clean; the pins carry no reset of their own
  initial
  begin
    {prev, armed, fast, bad} = 6'h00;
    rows = 0;
    pix = 0;
    steps = 0;
  end

  // a row is moved whenever phase three drops to all low; a wrong opening, or a row end not 8 steps long or with a register phase low, is flagged bad
  always @(image_b_ph)
  begin
    steps = (prev == 3'h0) ? 1 : steps + 1;
    if (prev == 3'h0 && image_b_ph != 3'h0 && image_b_ph != 3'h4)
      bad = 1'b1;
    if (prev == 3'h4 && image_b_ph == 3'h0)
    begin
      rows = rows + 1;
      armed = 1'b1;
      if (steps != 8 || !(reg_ph1 && reg_ph2))
        bad = 1'b1;
    end
    prev = image_b_ph;
  end

  // the phase that drops first in a line picks the amplifier
  always @(negedge reg_ph1 or negedge reg_ph2)
  begin
    if (armed)
      fast = !reg_ph2;
    armed = 1'b0;
  end

  // one charge packet sensed per reset pulse
  always @(posedge out_reset)
    pix = pix + 1;
endmodule : ccd_sensor_model

// File: ccd_seq_pkg.sv
package ccd_seq_pkg;

  localparam int CLK_PERIOD_PS    = 8000;
  localparam int TMR_W            = 16;

  // image clock times, ns
  localparam int T_IMG_PERIOD_NS  = 15000;
  localparam int T_IMG_WIDTH_NS   = 8000;
  localparam int T_IMG_OVERLAP_NS = 3000;
  localparam int T_IMG_LOW_NS     = 2000;
  localparam int T_DIR_NS         = 3000;
  localparam int T_DRI_NS         = 1000;

  // register clock times
  localparam int T_REG_PERIOD_NS  = 150;
  localparam int T_REG_OVERLAP_NS = 10;
  localparam int T_RESET_NS       = 20;
  localparam int PIX_RATE_KHZ     = 6000;

  // least times round up to whole cycles
  localparam int IMG_OVL_CYC  = (T_IMG_OVERLAP_NS * 1000 + CLK_PERIOD_PS - 1)
                                / CLK_PERIOD_PS;
  localparam int IMG_LOW_CYC  = (T_IMG_LOW_NS * 1000 + CLK_PERIOD_PS - 1)
                                / CLK_PERIOD_PS;
  // single-high dwell padded so every pulse meets the width minimum
  localparam int IMG_SGL_CYC  = ((T_IMG_WIDTH_NS - T_IMG_OVERLAP_NS) * 1000
                                + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int DIR_CYC      = (T_DIR_NS * 1000 + CLK_PERIOD_PS - 1)
                                / CLK_PERIOD_PS;
  localparam int DRI_CYC      = (T_DRI_NS * 1000 + CLK_PERIOD_PS - 1)
                                / CLK_PERIOD_PS;
  localparam int REG_OVL_CYC  = (T_REG_OVERLAP_NS * 1000 + CLK_PERIOD_PS - 1)
                                / CLK_PERIOD_PS;
  localparam int RST_CYC      = (T_RESET_NS * 1000 + CLK_PERIOD_PS - 1)
                                / CLK_PERIOD_PS;
  localparam int REG_PER_CYC  = (T_REG_PERIOD_NS * 1000 + CLK_PERIOD_PS - 1)
                                / CLK_PERIOD_PS;
  // pixel period from the 6 MHz ceiling, never under the register minimum
  localparam int PIX_RATE_CYC = (1000000000 / CLK_PERIOD_PS + PIX_RATE_KHZ - 1)
                                / PIX_RATE_KHZ;
  localparam int PIX_CYC      = (PIX_RATE_CYC > REG_PER_CYC) ? PIX_RATE_CYC
                                : REG_PER_CYC;
  // outside short phase-two mode, each phase alone-high for half of what the overlaps leave
  localparam int HALF_CYC     = (PIX_CYC - 2 * REG_OVL_CYC + 1) / 2;
  localparam int PH2_REST_CYC = HALF_CYC - RST_CYC;
  localparam int PH1_CYC      = HALF_CYC;
  localparam int PH2_SHORT_CYC = 1;
  localparam int PH1_LONG_CYC = PIX_CYC - 2 * REG_OVL_CYC - RST_CYC
                                - PH2_SHORT_CYC;

  // image steps of one row and register steps of one pixel
  localparam int IMG_LAST_STEP = 6;
  localparam int PIX_LAST_STEP = 4;

  // register step kinds, listed in low-noise time order
  localparam logic [2:0] K_PH2_RST = 3'h0;
  localparam logic [2:0] K_PH2     = 3'h1;
  localparam logic [2:0] K_BOTH_A  = 3'h2;
  localparam logic [2:0] K_PH1     = 3'h3;
  localparam logic [2:0] K_BOTH_B  = 3'h4;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_IMG  = 5'h02,
    ST_DIR  = 5'h04,
    ST_PIX  = 5'h08,
    ST_DRI  = 5'h10
  } seq_state_t;

endpackage : ccd_seq_pkg

// File: ccd_seq_sva.sv
`timescale 1ns/1ps
module ccd_seq_sva
  import ccd_seq_pkg::*;
#(
  parameter int ROWS = 1152,
  parameter int COLS = 1252
)
(
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [2:0] image_a_ph,
  input wire logic [2:0] image_b_ph,
  input wire logic       reg_ph1,
  input wire logic       reg_ph2,
  input wire logic       out_reset
);
  logic [2:0]  prev_reg;
  logic [15:0] stand_reg;
  logic [15:0] b_low_reg;
  logic [15:0] both_reg;
  logic [15:0] pix_reg;
  logic        orst_reg;
  wire         both_hi = reg_ph1 && reg_ph2;

  // run lengths; gap counters saturate so idle after reset counts as long
  always_ff @(posedge clk)
  begin
    prev_reg <= image_b_ph;
    orst_reg <= out_reset;
    stand_reg <= (image_b_ph != prev_reg) ? 16'h0001 : stand_reg + 16'h0001;
    b_low_reg <= (|image_b_ph) ? 16'h0000
                 : b_low_reg + {15'h0000, ~&b_low_reg};
    both_reg <= !both_hi ? 16'h0000 : both_reg + {15'h0000, ~&both_reg};
    pix_reg <= (out_reset && !orst_reg) ? 16'h0001
               : pix_reg + {15'h0000, ~&pix_reg};
    if (!rst_n)
    begin
      prev_reg <= 3'h0;
      b_low_reg <= 16'hFFFF;
      both_reg <= 16'hFFFF;
      pix_reg <= 16'hFFFF;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_rst_pulse;
    out_reset[*3] ##1 !out_reset;
  endsequence

  AST_PH3_FIRST: assert property (
    (prev_reg == 3'h0 && image_b_ph != 3'h0) |-> image_b_ph == 3'h4)
    else $error("image sequence did not open on phase three");
  AST_IMG_OVERLAP: assert property (
    (image_b_ph != prev_reg && $countones(prev_reg) == 2)
    |-> stand_reg >= IMG_OVL_CYC)
    else $error("image overlap too short");
  AST_IMG_SINGLE: assert property (
    (image_b_ph != prev_reg && $countones(prev_reg) == 1)
    |-> stand_reg >= IMG_SGL_CYC)
    else $error("image single-high dwell too short");
  AST_REG_HELD: assert property (|image_b_ph |-> both_hi)
    else $error("register phases low during row transfer");
  AST_DIR_GAP: assert property (
    !both_hi |-> b_low_reg >= DIR_CYC)
    else $error("register clocking too soon after image");
  AST_DRI_GAP: assert property (
    $rose(|image_b_ph) |-> both_reg >= DRI_CYC)
    else $error("image clocking too soon after register");
  AST_REG_OVERLAP: assert property (
    ($fell(reg_ph1) || $fell(reg_ph2))
    |-> $past(both_hi) && $past(both_hi, 2))
    else $error("register overlap too short");
  AST_RESET_PULSE: assert property (
    $rose(out_reset) |-> s_rst_pulse)
    else $error("reset pulse width wrong");
  AST_RESET_IN_PH2: assert property (
    out_reset |-> reg_ph2 && !reg_ph1)
    else $error("reset outside phase two alone");
  AST_PIX_PERIOD: assert property (
    $rose(out_reset) |-> pix_reg >= PIX_RATE_CYC)
    else $error("pixel period too short");
  AST_A_MODE: assert property (
    image_a_ph == image_b_ph || image_a_ph == 3'h0)
    else $error("section A differs from section B");
endmodule : ccd_seq_sva

bind ccd_clock_sequencer ccd_seq_sva #(.ROWS(ROWS), .COLS(COLS)) u_sva (
  .clk(clk), .rst_n(rst_n), .image_a_ph(image_a_ph),
  .image_b_ph(image_b_ph), .reg_ph1(reg_ph1), .reg_ph2(reg_ph2),
  .out_reset(out_reset));

// File: seq_timer.sv
`timescale 1ns/1ps
module seq_timer
  import ccd_seq_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  rst_n,
  seq_timer_if.timer tmr
);
  import ccd_seq_pkg::*;

  logic [TMR_W-1:0] cnt_reg;
  logic [TMR_W-1:0] cnt_next;

  // load len-1 so a step lasts exactly len cycles
  always_comb
  begin
    cnt_next = cnt_reg;
    if (tmr.load)
      cnt_next = tmr.len - TMR_W'(1);
    else if (cnt_reg != '0)
      cnt_next = cnt_reg - TMR_W'(1);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cnt_reg <= '0;
    else
      cnt_reg <= cnt_next;
  end

  assign tmr.done = (cnt_reg == '0);

endmodule : seq_timer

// File: seq_timer_if.sv
`timescale 1ns/1ps
// dwell timer carrier between sequencer and its timer
interface seq_timer_if
  import ccd_seq_pkg::*;
  ();
  logic             load;
  logic [TMR_W-1:0] len;
  logic             done;

  modport ctrl  (output load, output len, input done);
  modport timer (input load, input len, output done);
endinterface : seq_timer_if
